// [rtl/pcm_pkg.sv]
/*
  constants, types and bus carrier for the counter-array mode and
  pwm-configuration control block.
  assumes a byte-wide special-function-register bus in the core clock domain.
*/
package pcm_pkg;

  localparam logic [7:0] MODE_ADDR = 8'hd9;
  localparam logic [7:0] PWM_ADDR = 8'hdf;

  localparam int MD_IDLE = 7;
  localparam int MD_WDE = 6;
  localparam int MD_LOCK = 5;
  localparam int MD_TB_LO = 1;
  localparam int MD_OVF_MASK = 0;
  localparam int PW_RELOAD_SEL = 7;
  localparam int PW_CYC_MASK = 6;
  localparam int PW_CYC_FLAG = 5;
  localparam int PW_CLS_LO = 0;

  localparam logic RST_WDE = 1'b1;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [2:0] OSC_DIV_LAST = 3'h7;

  typedef enum logic [2:0] {
    TB_DIV12, TB_DIV4, TB_T0OVF, TB_EXT_FALL, TB_SYSCLK, TB_XOSC8, TB_RTC8, TB_NONE
  } pcm_tb_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcm_sfr_s;

endpackage

// [rtl/pcm_core.sv]
/*
  mode and pwm-configuration control of the programmable counter array:
  timebase, idle suspend, watchdog enable/lock, overflow flags, interrupt.
  assumes all inputs are synchronous to ref_clk except the two oscillator
  inputs, which are synchronised here.
*/
`timescale 1ns/1ns
module pcm_core
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register access
  input wire pcm_pkg::pcm_sfr_s sfr_req,
  output logic [7:0] sfr_rdata_q,
  // system and count sources
  input wire logic cpu_idle,
  input wire logic counter_run,
  input wire logic main_flag_clear,
  input wire logic timer0_ovf,
  input wire logic ext_count_input,
  input wire logic ext_osc_in,
  input wire logic rtc_osc_in,
  input wire logic [5:0] pwm16_sel,
  // state and requests
  output logic [15:0] counter_q,
  output logic main_overflow_flag_q,
  output logic cycle_overflow_flag_q,
  output logic irq_q,
  output logic wdog_active_q,
  output logic reload_sel_q,
  output logic [1:0] cycle_length_select_q,
  output logic [5:0] reload_used_q
);

  // true when the selected cycle bit overflows on the next increment
  function automatic logic cyc_wrap(input logic [15:0] cnt, input logic [1:0] sel);
    logic w;
    w = 1'b0;
    case (sel)
      2'h0: w = &cnt[7:0];
      2'h1: w = &cnt[8:0];
      2'h2: w = &cnt[9:0];
      default: w = &cnt[10:0];
    endcase
    return w;
  endfunction

  logic idle_suspend_q;
  logic wdog_enable_q;
  logic wdog_lock_q;
  pcm_pkg::pcm_tb_e timebase_select_q;
  logic overflow_irq_mask_q;
  logic cycle_overflow_irq_mask_q;
  logic [3:0] div12_q;
  logic [1:0] div4_q;
  logic ext_count_prev_q;
  logic [1:0] osc_s1_q;
  logic [1:0] osc_s2_q;
  logic [1:0] osc_s3_q;
  logic [2:0] osc_div_q [2];
  logic [1:0] osc_tick;
  logic wr_md;
  logic wr_pw;
  logic rd_md;
  logic rd_pw;
  logic run;
  logic tick;
  logic adv;
  logic cyc_hit;

  assign wr_md = sfr_req.wr && (sfr_req.addr == pcm_pkg::MODE_ADDR);
  assign wr_pw = sfr_req.wr && (sfr_req.addr == pcm_pkg::PWM_ADDR);
  assign rd_md = sfr_req.rd && (sfr_req.addr == pcm_pkg::MODE_ADDR);
  assign rd_pw = sfr_req.rd && (sfr_req.addr == pcm_pkg::PWM_ADDR);

  // watchdog forces the counter on; idle suspend still wins
  assign run = (counter_run | wdog_enable_q) & ~(idle_suspend_q & cpu_idle);
  assign cyc_hit = cyc_wrap(counter_q, cycle_length_select_q);

  always_comb
  begin
    tick = 1'b0;
    case (timebase_select_q)
      pcm_pkg::TB_DIV12: tick = (div12_q == pcm_pkg::DIV12_LAST);
      pcm_pkg::TB_DIV4: tick = (div4_q == pcm_pkg::DIV4_LAST);
      pcm_pkg::TB_T0OVF: tick = timer0_ovf;
      // falling edge; source must keep to clock/4 or edges merge
      pcm_pkg::TB_EXT_FALL: tick = ext_count_prev_q & ~ext_count_input;
      pcm_pkg::TB_SYSCLK: tick = 1'b1;
      pcm_pkg::TB_XOSC8: tick = osc_tick[0];
      pcm_pkg::TB_RTC8: tick = osc_tick[1];
      default: tick = 1'b0;
    endcase
  end

  assign adv = run & tick;

  // divide-by-12 and divide-by-4 prescalers only move while the array runs, so idle freezes them too
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      div12_q <= 4'h0;
      div4_q <= 2'h0;
    end
    else if (run)
    begin
      div12_q <= (div12_q == pcm_pkg::DIV12_LAST) ? 4'h0 : div12_q + 4'h1;
      div4_q <= div4_q + 2'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ext_count_prev_q <= 1'b1;
    else
      ext_count_prev_q <= ext_count_input;
  end

  // two-flop sync, edge taken between second and third stage
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      osc_s1_q <= 2'h0;
      osc_s2_q <= 2'h0;
      osc_s3_q <= 2'h0;
    end
    else
    begin
      osc_s1_q <= {rtc_osc_in, ext_osc_in};
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  always_comb
  begin
    for (int i = 0; i < 2; i++)
      osc_tick[i] = osc_s2_q[i] & ~osc_s3_q[i] & (osc_div_q[i] == pcm_pkg::OSC_DIV_LAST);
  end

  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (rst)
        osc_div_q[i] <= 3'h0;
      else if (osc_s2_q[i] & ~osc_s3_q[i])
        osc_div_q[i] <= osc_div_q[i] + 3'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      counter_q <= 16'h0000;
    else if (adv)
      counter_q <= counter_q + 16'h0001;
  end

  // hardware set beats a same-cycle software clear
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      main_overflow_flag_q <= 1'b0;
    else if (adv && counter_q == pcm_pkg::CNT_MAX)
      main_overflow_flag_q <= 1'b1;
    else if (main_flag_clear)
      main_overflow_flag_q <= 1'b0;
  end

  // mode register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      idle_suspend_q <= 1'b0;
      wdog_enable_q <= pcm_pkg::RST_WDE;
      wdog_lock_q <= 1'b0;
      timebase_select_q <= pcm_pkg::TB_DIV12;
      overflow_irq_mask_q <= 1'b0;
    end
    else if (wr_md)
    begin
      // lock forces enable; setting lock also enables
      wdog_enable_q <= wdog_lock_q | sfr_req.wdata[pcm_pkg::MD_WDE]
        | (~wdog_enable_q & sfr_req.wdata[pcm_pkg::MD_LOCK]);
      if (!wdog_enable_q)
      begin
        idle_suspend_q <= sfr_req.wdata[pcm_pkg::MD_IDLE];
        timebase_select_q <= pcm_pkg::pcm_tb_e'(sfr_req.wdata[pcm_pkg::MD_TB_LO +: 3]);
        overflow_irq_mask_q <= sfr_req.wdata[pcm_pkg::MD_OVF_MASK];
        wdog_lock_q <= wdog_lock_q | sfr_req.wdata[pcm_pkg::MD_LOCK];
      end
    end
  end

  // pwm configuration register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      reload_sel_q <= 1'b0;
      cycle_overflow_irq_mask_q <= 1'b0;
      cycle_length_select_q <= 2'h0;
    end
    else if (wr_pw)
    begin
      reload_sel_q <= sfr_req.wdata[pcm_pkg::PW_RELOAD_SEL];
      cycle_overflow_irq_mask_q <= sfr_req.wdata[pcm_pkg::PW_CYC_MASK];
      cycle_length_select_q <= sfr_req.wdata[pcm_pkg::PW_CLS_LO +: 2];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cycle_overflow_flag_q <= 1'b0;
    else if (adv && cyc_hit)
      cycle_overflow_flag_q <= 1'b1;
    else if (wr_pw)
      cycle_overflow_flag_q <= sfr_req.wdata[pcm_pkg::PW_CYC_FLAG];
  end

  // one-cycle lag behind the flags, accepted to keep outputs registered
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= (overflow_irq_mask_q & main_overflow_flag_q)
        | (cycle_overflow_irq_mask_q & cycle_overflow_flag_q);
  end

  // reload matters only for 9..11 bit cycles on non-16-bit channels
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      reload_used_q <= 6'h00;
    else
      reload_used_q <= ~pwm16_sel & {6{cycle_length_select_q != 2'h0}};
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      wdog_active_q <= pcm_pkg::RST_WDE;
    else
      wdog_active_q <= wdog_enable_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      sfr_rdata_q <= pcm_pkg::ZERO_BYTE;
    else if (rd_md)
      sfr_rdata_q <= {idle_suspend_q, wdog_enable_q, wdog_lock_q, 1'b0,
        timebase_select_q, overflow_irq_mask_q};
    else if (rd_pw)
      sfr_rdata_q <= {reload_sel_q, cycle_overflow_irq_mask_q, cycle_overflow_flag_q,
        3'h0, cycle_length_select_q};
    else
      sfr_rdata_q <= pcm_pkg::ZERO_BYTE;
  end

  a_idle_halt: assert property (@(posedge ref_clk) disable iff (rst)
    (idle_suspend_q && cpu_idle) |=> $stable(counter_q))
    else $error("counter moved while idle suspended");

  a_lock_hold: assert property (@(posedge ref_clk) disable iff (rst)
    wdog_lock_q |=> (wdog_enable_q && wdog_lock_q))
    else $error("locked watchdog became disabled");

  a_mode_frozen: assert property (@(posedge ref_clk) disable iff (rst)
    (wdog_enable_q && wr_md) |=> ($stable(timebase_select_q) && $stable(idle_suspend_q)
      && $stable(overflow_irq_mask_q)))
    else $error("mode bits changed while watchdog enabled");

  a_mode_rsvd: assert property (@(posedge ref_clk) disable iff (rst)
    rd_md |=> (sfr_rdata_q[4] == 1'b0 && sfr_rdata_q[6] == $past(wdog_enable_q)))
    else $error("mode read back wrong");

  a_div12_rate: assert property (@(posedge ref_clk) disable iff (rst)
    (adv && timebase_select_q == pcm_pkg::TB_DIV12)
      |-> ##1 (!adv || timebase_select_q != pcm_pkg::TB_DIV12) [*8])
    else $error("divide-by-12 timebase ticked too soon");

  a_main_wrap: assert property (@(posedge ref_clk) disable iff (rst)
    (adv && counter_q == pcm_pkg::CNT_MAX)
      |=> (main_overflow_flag_q && counter_q == 16'h0000))
    else $error("main overflow not flagged on wrap");

  a_cyc_set: assert property (@(posedge ref_clk) disable iff (rst)
    (adv && cyc_hit) |=> cycle_overflow_flag_q)
    else $error("cycle overflow flag not set");

  a_cyc_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    (cycle_overflow_flag_q && !wr_pw) |=> cycle_overflow_flag_q)
    else $error("cycle overflow flag cleared by hardware");

  a_irq_gate: assert property (@(posedge ref_clk) disable iff (rst)
    ((overflow_irq_mask_q && main_overflow_flag_q)
      || (cycle_overflow_irq_mask_q && cycle_overflow_flag_q)) |=> irq_q)
    else $error("interrupt request missing");

  a_pwm_rsvd: assert property (@(posedge ref_clk) disable iff (rst)
    rd_pw |=> (sfr_rdata_q[4:2] == 3'h0))
    else $error("pwm reserved bits not zero");

  a_wide_ignore: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> ((reload_used_q & $past(pwm16_sel)) == 6'h00))
    else $error("16-bit channel affected by cycle length");

endmodule

// [verif/tb_top.sv]
/*
  self-checking bench for the counter-array mode and pwm-configuration block.
  assumes pcm_core with a 100 MHz ref_clk and synchronous active-high rst.
*/
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [5:0] p16;
    logic [7:0] rd;
    logic [5:0] used;
  } pcm_row_s;
  typedef struct packed {
    logic [7:0] mode;
    logic idle;
    logic [15:0] delta;
  } pcm_tb_row_s;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  pcm_pkg::pcm_sfr_s req = '0;
  logic cpu_idle = 1'b0;
  logic counter_run = 1'b1;
  logic main_flag_clear = 1'b0;
  logic timer0_ovf = 1'b0;
  logic ext_count_input = 1'b0;
  logic ext_osc_in = 1'b0;
  logic rtc_osc_in = 1'b1;
  logic [5:0] pwm16_sel = 6'h00;
  logic [7:0] sfr_rdata_q;
  logic [15:0] counter_q;
  logic main_overflow_flag_q;
  logic cycle_overflow_flag_q;
  logic irq_q;
  logic wdog_active_q;
  logic reload_sel_q;
  logic [1:0] cycle_length_select_q;
  logic [5:0] reload_used_q;
  int n_fail = 0;
  int checked = 0;
  int k = 0;
  pcm_row_s rows [13] = '{
    '{8'hd9, 8'hff, 6'h00, 8'h40, 6'h00}, '{8'hd9, 8'h00, 6'h00, 8'h00, 6'h00},
    '{8'hd9, 8'h10, 6'h00, 8'h00, 6'h00}, '{8'hd9, 8'h9f, 6'h00, 8'h8f, 6'h00},
    '{8'h55, 8'hff, 6'h00, 8'h00, 6'h00}, '{8'hd9, 8'h00, 6'h00, 8'h00, 6'h00},
    '{8'hdf, 8'h1c, 6'h00, 8'h00, 6'h00}, '{8'hdf, 8'h81, 6'h00, 8'h81, 6'h3f},
    '{8'hdf, 8'h02, 6'h05, 8'h02, 6'h3a}, '{8'hdf, 8'h03, 6'h3f, 8'h03, 6'h00},
    '{8'hdf, 8'h00, 6'h00, 8'h00, 6'h00}, '{8'hdf, 8'hff, 6'h01, 8'he3, 6'h3e},
    '{8'hdf, 8'h00, 6'h00, 8'h00, 6'h00}};
  // expected counts over 96 cycles for the periodic sources below
  pcm_tb_row_s tbs [11] = '{
    '{8'h00, 1'b0, 16'h0008}, '{8'h02, 1'b0, 16'h0018}, '{8'h04, 1'b0, 16'h0020},
    '{8'h06, 1'b0, 16'h000c}, '{8'h08, 1'b0, 16'h0060}, '{8'h0a, 1'b0, 16'h0003},
    '{8'h0c, 1'b0, 16'h0003}, '{8'h0e, 1'b0, 16'h0000}, '{8'h88, 1'b1, 16'h0000},
    '{8'h88, 1'b0, 16'h0060}, '{8'h08, 1'b1, 16'h0060}};

  pcm_core dut (
    .ref_clk(ref_clk), .rst(rst), .sfr_req(req), .sfr_rdata_q(sfr_rdata_q),
    .cpu_idle(cpu_idle), .counter_run(counter_run), .main_flag_clear(main_flag_clear),
    .timer0_ovf(timer0_ovf), .ext_count_input(ext_count_input),
    .ext_osc_in(ext_osc_in), .rtc_osc_in(rtc_osc_in), .pwm16_sel(pwm16_sel),
    .counter_q(counter_q), .main_overflow_flag_q(main_overflow_flag_q),
    .cycle_overflow_flag_q(cycle_overflow_flag_q), .irq_q(irq_q),
    .wdog_active_q(wdog_active_q), .reload_sel_q(reload_sel_q),
    .cycle_length_select_q(cycle_length_select_q), .reload_used_q(reload_used_q));

  always #5 ref_clk = ~ref_clk;

  // periodic sources; ext edges every 8 cycles, well under clock/4
  always @(negedge ref_clk)
  begin
    k <= k + 1;
    timer0_ovf <= (k % 3 == 0);
    ext_count_input <= k[2];
    ext_osc_in <= k[1];
    rtc_osc_in <= ~k[1];
  end

  task automatic finish_test();
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge ref_clk);
    req.wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge ref_clk);
    req.rd = 1'b0;
    d = sfr_rdata_q;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
  endtask

  initial
  begin
    #1_000_000;
    n_fail++;
    finish_test();
  end

  initial
  begin
    logic [7:0] d;
    logic [15:0] c0;
    logic [15:0] m;
    int n;
    do_reset();
    check(16'(wdog_active_q), 16'h0001);
    foreach (rows[i])
    begin
      pwm16_sel = rows[i].p16;
      wr_reg(rows[i].addr, rows[i].wdata);
      rd_reg(rows[i].addr, d);
      check(16'(d), 16'(rows[i].rd));
      check(16'(reload_used_q), 16'(rows[i].used));
      if (i == 7)
        check(16'(reload_sel_q), 16'h0001);
    end
    check(16'(wdog_active_q), 16'h0000);
    foreach (tbs[i])
    begin
      wr_reg(8'hd9, tbs[i].mode);
      cpu_idle = tbs[i].idle;
      repeat (16) @(negedge ref_clk);
      c0 = counter_q;
      repeat (96) @(negedge ref_clk);
      check(counter_q - c0, tbs[i].delta);
    end
    cpu_idle = 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(8'hdf, 8'(c));
      m = 16'((1 << (8 + c)) - 1);
      check(16'(cycle_length_select_q), 16'(c));
      n = 0;
      while (cycle_overflow_flag_q !== 1'b1 && n < 4200)
      begin
        @(negedge ref_clk);
        n++;
      end
      check(counter_q & m, 16'h0000);
      repeat (3) @(negedge ref_clk);
      check(16'(cycle_overflow_flag_q), 16'h0001);
      check(16'(irq_q), 16'h0000);
    end
    wr_reg(8'hdf, 8'h63);
    repeat (2) @(negedge ref_clk);
    check(16'(irq_q), 16'h0001);
    wr_reg(8'hdf, 8'h03);
    repeat (2) @(negedge ref_clk);
    check(16'(cycle_overflow_flag_q), 16'h0000);
    check(16'(irq_q), 16'h0000);
    // one full wrap at sysclk rate is the long part of the run
    n = 0;
    while (main_overflow_flag_q !== 1'b1 && n < 70000)
    begin
      @(negedge ref_clk);
      n++;
    end
    check(counter_q, 16'h0000);
    check(16'(irq_q), 16'h0000);
    wr_reg(8'hd9, 8'h09);
    repeat (2) @(negedge ref_clk);
    check(16'(irq_q), 16'h0001);
    check(16'(main_overflow_flag_q), 16'h0001);
    main_flag_clear = 1'b1;
    @(negedge ref_clk);
    main_flag_clear = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(16'(main_overflow_flag_q), 16'h0000);
    check(16'(irq_q), 16'h0000);
    // run control off and watchdog off: the counter must stand
    counter_run = 1'b0;
    c0 = counter_q;
    repeat (16) @(negedge ref_clk);
    check(counter_q - c0, 16'h0000);
    wr_reg(8'hd9, 8'h20);
    wr_reg(8'hd9, 8'h00);
    rd_reg(8'hd9, d);
    check(16'(d), 16'h0060);
    check(16'(wdog_active_q), 16'h0001);
    // enabled watchdog forces the counter on despite run control low
    c0 = counter_q;
    repeat (24) @(negedge ref_clk);
    check(counter_q - c0, 16'h0002);
    do_reset();
    rd_reg(8'hd9, d);
    check(16'(d), 16'h0040);
    rd_reg(8'hdf, d);
    check(16'(d), 16'h0000);
    finish_test();
  end
endmodule
